// File: cpu_flags_addr.sv
`timescale 1ns/1ps
module cpu_flags_addr (
  input  wire logic                     CLK_IN,
  input  wire logic                     RST_IN,
  input  wire cpu_flags_pkg::flag_req_t FLAG_REQ_IN,
  input  wire cpu_flags_pkg::addr_req_t ADDR_REQ_IN,
  input  wire logic                     IRQ_IN,
  input  wire logic                     BOUNDARY_IN,
  input  wire logic                     STACK_DONE_IN,
  output logic [7:0]                    CCR_OUT,
  output logic [7:0]                    ALU_RES_OUT,
  output logic                          IRQ_TAKE_OUT,
  output cpu_flags_pkg::addr_resp_t     RESP_OUT,
  input  wire logic [31:0]              AXI_AWADDR_IN,
  input  wire logic                     AXI_AWVALID_IN,
  output logic                          AXI_AWREADY_OUT,
  input  wire logic [31:0]              AXI_WDATA_IN,
  input  wire logic [3:0]               AXI_WSTRB_IN,
  input  wire logic                     AXI_WVALID_IN,
  output logic                          AXI_WREADY_OUT,
  output logic [1:0]                    AXI_BRESP_OUT,
  output logic                          AXI_BVALID_OUT,
  input  wire logic                     AXI_BREADY_IN,
  input  wire logic [31:0]              AXI_ARADDR_IN,
  input  wire logic                     AXI_ARVALID_IN,
  output logic                          AXI_ARREADY_OUT,
  output logic [31:0]                   AXI_RDATA_OUT,
  output logic [1:0]                    AXI_RRESP_OUT,
  output logic                          AXI_RVALID_OUT,
  input  wire logic                     AXI_RREADY_IN
);
  import cpu_flags_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] nz_of(input logic [15:0] v,
                                       input logic        wide);
    nz_of = wide ? {v[15], v == 16'h0000}
                 : {v[7], v[7:0] == 8'h00};
  endfunction

  function automatic logic [15:0] ea_of(input addr_mode_t m,
                                        input logic       dst,
                                        input addr_req_t  r);
    logic [15:0] zp1;
    logic [15:0] zp2;
    zp1 = {8'h00, r.b1};
    zp2 = {8'h00, r.b2};
    case (m)
      no_operand_mode:      ea_of = 16'h0000;
      branch_offset_mode:   ea_of = r.pc + 16'h0001;
      literal_operand_mode: ea_of = r.pc + 16'h0001;
      mode_dir:             ea_of = zp1;
      mode_ext:             ea_of = {r.b1, r.b2};
      mode_ix, mode_ix_inc: ea_of = r.hx;
      mode_ix1, mode_ix1_inc: ea_of = r.hx + zp1;
      mode_ix2:             ea_of = r.hx + {r.b1, r.b2};
      mode_sp1:             ea_of = r.sp + zp1;
      mode_sp2:             ea_of = r.sp + {r.b1, r.b2};
      mode_dir_dir:         ea_of = dst ? zp2 : zp1;
      mode_lit_dir:         ea_of = dst ? zp2 : r.pc + 16'h0001;
      mode_ix_inc_dir:      ea_of = dst ? zp1 : r.hx;
      mode_dir_ix_inc:      ea_of = dst ? r.hx : zp1;
      default:              ea_of = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Condition codes and interrupt gate
  // ----------------------------------------------------------------
  logic [7:0] ccr_q, ccr_d, alu_q, alu_d;
  logic       take_q, take_d, inhibit_q, inhibit_d, busy_q, busy_d;
  logic       ccr_wr;
  logic [7:0] ccr_wdata;
  logic [8:0] s9;
  logic [4:0] s5;
  logic [1:0] nz;
  logic       cin;

  always_comb begin
    ccr_d     = ccr_q;
    alu_d     = alu_q;
    inhibit_d = inhibit_q;
    busy_d    = busy_q;
    s9        = 9'h000;
    s5        = 5'h00;
    cin       = (FLAG_REQ_IN.op == fop_adc || FLAG_REQ_IN.op == fop_sbc)
                && ccr_q[CCR_C];
    nz        = nz_of(FLAG_REQ_IN.value, FLAG_REQ_IN.wide);
    if (FLAG_REQ_IN.valid) begin
      case (FLAG_REQ_IN.op)
        fop_add, fop_adc: begin
          s9 = {1'b0, FLAG_REQ_IN.a} + {1'b0, FLAG_REQ_IN.b} + {8'h00, cin};
          s5 = {1'b0, FLAG_REQ_IN.a[3:0]} + {1'b0, FLAG_REQ_IN.b[3:0]}
               + {4'h0, cin};
          ccr_d[CCR_C] = s9[8];
          ccr_d[CCR_H] = s5[4];
          ccr_d[CCR_V] = (FLAG_REQ_IN.a[7] == FLAG_REQ_IN.b[7])
                         && (s9[7] != FLAG_REQ_IN.a[7]);
        end
        fop_sub, fop_sbc: begin
          s9 = {1'b0, FLAG_REQ_IN.a} - {1'b0, FLAG_REQ_IN.b} - {8'h00, cin};
          ccr_d[CCR_C] = s9[8];
          ccr_d[CCR_V] = (FLAG_REQ_IN.a[7] != FLAG_REQ_IN.b[7])
                         && (s9[7] != FLAG_REQ_IN.a[7]);
        end
        fop_logic, fop_move: begin
          ccr_d[CCR_N] = nz[1];
          ccr_d[CCR_Z] = nz[0];
          ccr_d[CCR_V] = 1'b0;
        end
        fop_shift: begin
          ccr_d[CCR_N] = nz[1];
          ccr_d[CCR_Z] = nz[0];
          ccr_d[CCR_C] = FLAG_REQ_IN.carry;
          ccr_d[CCR_V] = nz[1] ^ FLAG_REQ_IN.carry;
        end
        fop_bit_branch: ccr_d[CCR_C] = FLAG_REQ_IN.carry;
        fop_clear_mask: ccr_d[CCR_I] = 1'b0;
        fop_set_mask:   ccr_d[CCR_I] = 1'b1;
        fop_to_flags:   ccr_d = FLAG_REQ_IN.a;
        default: ;
      endcase
      if (FLAG_REQ_IN.op inside {fop_add, fop_adc, fop_sub, fop_sbc}) begin
        ccr_d[CCR_N] = s9[7];
        ccr_d[CCR_Z] = s9[7:0] == 8'h00;
        alu_d        = s9[7:0];
      end
    end else if (ccr_wr) begin
      // Core updates win; a bus write in the same cycle is dropped
      ccr_d = ccr_wdata;
    end
    if (ccr_q[CCR_I] && !ccr_d[CCR_I]) begin
      inhibit_d = 1'b1;
    end else if (BOUNDARY_IN) begin
      inhibit_d = 1'b0;
    end
    take_d = BOUNDARY_IN && IRQ_IN && !ccr_q[CCR_I] && !inhibit_q
             && !busy_q;
    if (take_d) begin
      busy_d = 1'b1;
    end
    if (STACK_DONE_IN) begin
      ccr_d[CCR_I] = 1'b1;
      busy_d       = 1'b0;
    end
    ccr_d = ccr_d | CCR_FIXED;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ccr_q     <= CCR_RST;
      alu_q     <= 8'h00;
      take_q    <= 1'b0;
      inhibit_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      ccr_q     <= ccr_d;
      alu_q     <= alu_d;
      take_q    <= take_d;
      inhibit_q <= inhibit_d;
      busy_q    <= busy_d;
    end
  end

  assign CCR_OUT      = ccr_q;
  assign ALU_RES_OUT  = alu_q;
  assign IRQ_TAKE_OUT = take_q;

  // ----------------------------------------------------------------
  // Operand addressing
  // ----------------------------------------------------------------
  addr_resp_t resp_q, resp_d;
  addr_mode_t mode_q, mode_d;
  logic [15:0] seq_pc;

  always_comb begin
    mode_d = mode_q;
    seq_pc = ADDR_REQ_IN.pc + {13'h0000, ADDR_REQ_IN.len};
    // Fields hold the last answer for the status and address reads
    resp_d = resp_q;
    // Single registered stage: no cycles beyond the bus accesses
    resp_d.valid = ADDR_REQ_IN.valid;
    if (ADDR_REQ_IN.valid) begin
      mode_d            = ADDR_REQ_IN.src_mode;
      resp_d.operand    = 16'h0000;
      resp_d.src_ea     = ea_of(ADDR_REQ_IN.src_mode, 1'b0, ADDR_REQ_IN);
      resp_d.dst_ea     = ADDR_REQ_IN.has_dst
                          ? ea_of(ADDR_REQ_IN.dst_mode, 1'b1, ADDR_REQ_IN)
                          : resp_d.src_ea;
      resp_d.mem_access = !(ADDR_REQ_IN.src_mode inside
                            {no_operand_mode, branch_offset_mode,
                             literal_operand_mode});
      if (ADDR_REQ_IN.src_mode == literal_operand_mode) begin
        resp_d.operand = ADDR_REQ_IN.wide_lit
                         ? {ADDR_REQ_IN.b1, ADDR_REQ_IN.b2}
                         : {8'h00, ADDR_REQ_IN.b1};
      end else if (ADDR_REQ_IN.src_mode == mode_lit_dir) begin
        resp_d.operand = {8'h00, ADDR_REQ_IN.b1};
      end
      resp_d.taken   = ADDR_REQ_IN.branch && ADDR_REQ_IN.cond;
      resp_d.next_pc = resp_d.taken
                       ? seq_pc + {{8{ADDR_REQ_IN.rel_off[7]}},
                                   ADDR_REQ_IN.rel_off}
                       : seq_pc;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      resp_q <= '0;
      mode_q <= no_operand_mode;
    end else begin
      resp_q <= resp_d;
      mode_q <= mode_d;
    end
  end

  assign RESP_OUT = resp_q;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ccr_wr    = 1'b0;
    ccr_wdata = wdata_q[7:0];
    if (bvalid_q && AXI_BREADY_IN) begin
      bvalid_d = 1'b0;
    end
    if (AXI_AWVALID_IN && awrdy_q) begin
      aw_got_d = 1'b1;
      awaddr_d = AXI_AWADDR_IN[11:0];
    end
    if (AXI_WVALID_IN && wrdy_q) begin
      w_got_d  = 1'b1;
      wdata_d  = AXI_WDATA_IN;
      wstrb0_d = AXI_WSTRB_IN[0];
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (awaddr_q == OFS_CCR) begin
        ccr_wr = wstrb0_q;
      end else if (awaddr_q != OFS_STAT && awaddr_q != OFS_EA) begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (rvalid_q && AXI_RREADY_IN) begin
      rvalid_d = 1'b0;
    end
    if (AXI_ARVALID_IN && arrdy_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (AXI_ARADDR_IN[11:0])
        OFS_CCR:  rdata_d = {24'h000000, ccr_q};
        OFS_STAT: rdata_d = {24'h000000, busy_q, inhibit_q, resp_q.taken,
                             resp_q.mem_access, mode_q};
        OFS_EA:   rdata_d = {16'h0000, resp_q.src_ea};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    // One write and one read in flight; ready drops while busy
    awrdy_d = !aw_got_d && !bvalid_d;
    wrdy_d  = !w_got_d && !bvalid_d;
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h00000000;
      wstrb0_q <= 1'b0;
      awrdy_q  <= 1'b0;
      wrdy_q   <= 1'b0;
      arrdy_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb0_q <= wstrb0_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
      arrdy_q  <= arrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign AXI_AWREADY_OUT = awrdy_q;
  assign AXI_WREADY_OUT  = wrdy_q;
  assign AXI_BVALID_OUT  = bvalid_q;
  assign AXI_BRESP_OUT   = bresp_q;
  assign AXI_ARREADY_OUT = arrdy_q;
  assign AXI_RVALID_OUT  = rvalid_q;
  assign AXI_RRESP_OUT   = rresp_q;
  assign AXI_RDATA_OUT   = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_mask_blocks: assert property (
    IRQ_TAKE_OUT |-> !$past(ccr_q[CCR_I]) && $past(IRQ_IN))
    else $error("interrupt taken while masked");
  a_mask_after_save: assert property (
    STACK_DONE_IN |=> ccr_q[CCR_I])
    else $error("mask not set after stack save");
  a_clear_inhibit: assert property (
    FLAG_REQ_IN.valid && FLAG_REQ_IN.op == fop_clear_mask && ccr_q[CCR_I]
    ##1 (BOUNDARY_IN or (!BOUNDARY_IN ##1 BOUNDARY_IN))
    |=> !IRQ_TAKE_OUT)
    else $error("interrupt right after mask clear");
  a_neg_move: assert property (
    FLAG_REQ_IN.valid && FLAG_REQ_IN.op == fop_move && FLAG_REQ_IN.wide
    |=> ccr_q[CCR_N] == $past(FLAG_REQ_IN.value[15]))
    else $error("negative flag wrong on move");
  a_zero_logic: assert property (
    FLAG_REQ_IN.valid && FLAG_REQ_IN.op == fop_logic && !FLAG_REQ_IN.wide
    |=> ccr_q[CCR_Z] == ($past(FLAG_REQ_IN.value[7:0]) == 8'h00))
    else $error("zero flag wrong on logic");
  a_carry_add: assert property (
    FLAG_REQ_IN.valid && FLAG_REQ_IN.op == fop_add
    |=> ccr_q[CCR_C] == ($past({1'b0, FLAG_REQ_IN.a})
                         + $past({1'b0, FLAG_REQ_IN.b}) > 9'h0ff))
    else $error("carry wrong on add");
  a_fixed_ones: assert property (
    ccr_q[6:5] == 2'h3)
    else $error("fixed ccr bits not one");
  a_one_cycle: assert property (
    ADDR_REQ_IN.valid |=> RESP_OUT.valid)
    else $error("address answer late");
  a_inherent_no_access: assert property (
    ADDR_REQ_IN.valid && ADDR_REQ_IN.src_mode == no_operand_mode
    |=> !RESP_OUT.mem_access)
    else $error("inherent mode accessed memory");
  a_branch_target: assert property (
    ADDR_REQ_IN.valid && ADDR_REQ_IN.branch && ADDR_REQ_IN.cond
    |=> RESP_OUT.next_pc == $past(ADDR_REQ_IN.pc
        + {13'h0000, ADDR_REQ_IN.len}
        + {{8{ADDR_REQ_IN.rel_off[7]}}, ADDR_REQ_IN.rel_off}))
    else $error("branch target wrong");
  a_lit_value: assert property (
    ADDR_REQ_IN.valid && ADDR_REQ_IN.src_mode == literal_operand_mode
    && !ADDR_REQ_IN.wide_lit
    |=> RESP_OUT.operand == {8'h00, $past(ADDR_REQ_IN.b1)})
    else $error("literal operand wrong");

endmodule

// File: cpu_flags_pkg.sv
package cpu_flags_pkg;

  // ----------------------------------------------------------------
  // Condition code layout
  // ----------------------------------------------------------------
  localparam int         CCR_V     = 7;
  localparam int         CCR_H     = 4;
  localparam int         CCR_I     = 3;
  localparam int         CCR_N     = 2;
  localparam int         CCR_Z     = 1;
  localparam int         CCR_C     = 0;
  localparam logic [7:0] CCR_FIXED = 8'h60;
  localparam logic [7:0] CCR_RST   = 8'h68;

  // ----------------------------------------------------------------
  // Register map and bus answers
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CCR     = 12'h000;
  localparam logic [11:0] OFS_STAT    = 12'h004;
  localparam logic [11:0] OFS_EA      = 12'h008;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    no_operand_mode, branch_offset_mode, literal_operand_mode,
    mode_dir, mode_ext, mode_ix, mode_ix_inc, mode_ix1, mode_ix1_inc,
    mode_ix2, mode_sp1, mode_sp2, mode_dir_dir, mode_lit_dir,
    mode_ix_inc_dir, mode_dir_ix_inc
  } addr_mode_t;

  typedef enum logic [3:0] {
    fop_none, fop_add, fop_adc, fop_sub, fop_sbc, fop_logic, fop_move,
    fop_shift, fop_bit_branch, fop_clear_mask, fop_set_mask, fop_to_flags
  } flag_op_t;

  typedef struct packed {
    logic        valid;
    flag_op_t    op;
    logic        wide;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] value;
    logic        carry;
  } flag_req_t;

  typedef struct packed {
    logic        valid;
    addr_mode_t  src_mode;
    addr_mode_t  dst_mode;
    logic        has_dst;
    logic        branch;
    logic        cond;
    logic        wide_lit;
    logic [15:0] pc;
    logic [2:0]  len;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  rel_off;
  } addr_req_t;

  typedef struct packed {
    logic        valid;
    logic        mem_access;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [15:0] operand;
    logic [15:0] next_pc;
    logic        taken;
  } addr_resp_t;

endpackage

// File: stack_save_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Stack save sequencer model
// ------------------------------------------------------------------
module stack_save_model #(
  parameter int DELAY = 3
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic take_in,
  output logic      done_out
);
  int cnt;

  // Pushes take DELAY cycles, so the mask stays clear meanwhile
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt      <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (take_in) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt      <= 0;
        done_out <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: tb_cpu_flags_and_operand_addressing.sv
`timescale 1ns/1ps
module tb_cpu_flags_and_operand_addressing;
  import cpu_flags_pkg::*;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic        clk, rst, irq, bnd, sdone, take;
  flag_req_t   freq;
  addr_req_t   areq;
  addr_resp_t  resp;
  logic [7:0]  condition_code_register, alu, ccr_m;
  logic [15:0] ea_m;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          miscompares, n_tests, i, n;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  cpu_flags_addr uut (
    .CLK_IN(clk), .RST_IN(rst), .FLAG_REQ_IN(freq), .ADDR_REQ_IN(areq),
    .IRQ_IN(irq), .BOUNDARY_IN(bnd), .STACK_DONE_IN(sdone),
    .CCR_OUT(condition_code_register), .ALU_RES_OUT(alu), .IRQ_TAKE_OUT(take),
    .RESP_OUT(resp), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
    .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready)
  );

  stack_save_model #(.DELAY(3)) saver (
    .clk_in(clk), .rst_in(rst), .take_in(take), .done_out(sdone)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Write channels held until each ready, bready held until bvalid
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bit aw, w;
    aw = 1;
    w  = 1;
    @(posedge clk);
    awaddr  <= {20'h0, a};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
      if (!aw && !w && bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    bit ar;
    ar = 1;
    @(posedge clk);
    araddr  <= {20'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar && arready) begin
        ar = 0;
        arvalid <= 1'b0;
      end
      if (!ar && rvalid) break;
    end
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // Flag model; bits the rules leave open are masked, then resynced
  task automatic flag(input flag_op_t op, input logic wd,
                      input logic [7:0] a, b, input logic [15:0] v,
                      input logic c);
    int r;
    logic [7:0] care, res;
    logic ci, nn, zz, ar;
    care = 8'hff;
    res  = 8'h00;
    ar   = op inside {fop_add, fop_adc, fop_sub, fop_sbc};
    ci   = (op == fop_adc || op == fop_sbc) ? ccr_m[CCR_C] : 1'b0;
    nn   = wd ? v[15] : v[7];
    zz   = wd ? (v == 16'h0000) : (v[7:0] == 8'h00);
    if (op == fop_add || op == fop_adc) begin
      r = a + b + ci;
      res = r[7:0];
      ccr_m[CCR_H] = (a[3:0] + b[3:0] + ci) > 15;
      ccr_m[CCR_V] = ~(a[7] ^ b[7]) & (a[7] ^ res[7]);
      ccr_m[CCR_C] = r > 255;
    end else if (ar) begin
      r = a - b - ci;
      res = r[7:0];
      care[CCR_H] = 1'b0;
      ccr_m[CCR_V] = (a[7] ^ b[7]) & (a[7] ^ res[7]);
      ccr_m[CCR_C] = r < 0;
    end else if (op == fop_logic || op == fop_move) begin
      ccr_m[CCR_V] = 1'b0;
      care = 8'hee;
    end else if (op == fop_shift) begin
      ccr_m[CCR_C] = c;
      ccr_m[CCR_V] = nn ^ c;
      care[CCR_H] = 1'b0;
    end else if (op == fop_bit_branch) begin
      ccr_m[CCR_C] = c;
      care = 8'h01;
    end else if (op == fop_clear_mask || op == fop_set_mask) begin
      ccr_m[CCR_I] = op == fop_set_mask;
    end else if (op == fop_to_flags) begin
      ccr_m = a | CCR_FIXED;
    end
    if (ar) begin
      nn = res[7];
      zz = res == 8'h00;
    end
    if (ar || op inside {fop_logic, fop_move, fop_shift}) begin
      ccr_m[CCR_N] = nn;
      ccr_m[CCR_Z] = zz;
    end
    @(posedge clk);
    freq <= '{1'b1, op, wd, a, b, v, c};
    @(posedge clk);
    freq.valid <= 1'b0;
    #1;
    chk("ccr", 32'(condition_code_register & care),
        32'(ccr_m & care));
    if (ar) chk("alu_res", 32'(alu), 32'(res));
    ccr_m = (ccr_m & care) | (condition_code_register & ~care);
  endtask

  task automatic bnd_chk(input logic exp);
    @(posedge clk);
    bnd <= 1'b1;
    @(posedge clk);
    bnd <= 1'b0;
    #1;
    chk("irq_take", 32'(take), 32'(exp));
  endtask

  task automatic wait_saved();
    n = 0;
    chk("mask_before_save", 32'(condition_code_register[CCR_I]), 32'h0);
    while (sdone !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("save_done", 32'(sdone), 32'h1);
    @(posedge clk);
    #1;
    ccr_m[CCR_I] = 1'b1;
    chk("mask_after_save", 32'(condition_code_register[CCR_I]), 32'h1);
  endtask

  task automatic addr_chk(input addr_mode_t m, input logic br, cd, wl,
                          input logic [2:0] ln, input logic [7:0] off);
    logic [15:0] hx, sp, pc, src, dst;
    logic [7:0]  b1, b2;
    logic        mem, ks, kd;
    {hx, sp} = $urandom;
    pc  = 16'($urandom);
    {b1, b2} = 16'($urandom);
    mem = 1'b1;
    ks  = 1'b1;
    kd  = 1'b1;
    src = {8'h00, b1};
    dst = {8'h00, b2};
    case (m)
      no_operand_mode, branch_offset_mode, literal_operand_mode: begin
        mem = 1'b0;
        ks  = 1'b0;
      end
      mode_ext:                src = {b1, b2};
      mode_ix, mode_ix_inc:    src = hx;
      mode_ix1, mode_ix1_inc:  src = hx + b1;
      mode_ix2:                src = hx + {b1, b2};
      mode_sp1:                src = sp + b1;
      mode_sp2:                src = sp + {b1, b2};
      mode_lit_dir:            ks = 1'b0;
      mode_ix_inc_dir:         {src, dst} = {hx, 8'h00, b1};
      mode_dir_ix_inc:         dst = hx;
      default:                 ;
    endcase
    kd = kd && m inside {mode_dir_dir, mode_lit_dir, mode_ix_inc_dir,
                         mode_dir_ix_inc};
    if (ks) ea_m = src;
    @(posedge clk);
    areq <= '{1'b1, m, m, kd, br, cd, wl, pc, ln, hx, sp, b1, b2, off};
    @(posedge clk);
    areq.valid <= 1'b0;
    #1;
    chk("resp_valid", 32'(resp.valid), 32'h1);
    chk("mem_access", 32'(resp.mem_access), 32'(mem));
    chk("next_pc", 32'(resp.next_pc), 32'(16'(pc + ln +
        ((br && cd) ? {{8{off[7]}}, off} : 16'h0))));
    chk("taken", 32'(resp.taken), 32'(br && cd));
    if (ks) chk("src_ea", 32'(resp.src_ea), 32'(src));
    if (kd) chk("dst_ea", 32'(resp.dst_ea), 32'(dst));
    if (m == literal_operand_mode) chk("operand", 32'(resp.operand),
        32'(wl ? {b1, b2} : {8'h00, b1}));
    @(posedge clk);
    #1;
    chk("resp_single", 32'(resp.valid), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {rst, irq, bnd, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
    {awaddr, wdata, araddr, wstrb} = '0;
    freq = '0;
    areq = '0;
    miscompares = 0;
    n_tests = 0;
    ea_m = 16'h0000;
    void'($urandom(75766));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    ccr_m = CCR_RST;
    axi_rd(OFS_CCR, 32'(CCR_RST), RESP_OKAY);
    axi_rd(12'h00c, 32'h0, RESP_SLVERR);
    axi_wr(12'h010, 32'h1, 4'hf, RESP_SLVERR);
    axi_wr(OFS_STAT, $urandom, 4'hf, RESP_OKAY);
    axi_wr(OFS_CCR, 32'h0, 4'h0, RESP_OKAY);
    axi_rd(OFS_CCR, 32'(ccr_m), RESP_OKAY);
    // Keeps I set, so no inhibit is armed before the interrupt test
    axi_wr(OFS_CCR, 32'hffff_ff8d, 4'hf, RESP_OKAY);
    ccr_m = 8'hed;
    axi_rd(OFS_CCR, 32'h0000_00ed, RESP_OKAY);
    flag(fop_add, 1'b0, 8'hff, 8'h01, 16'h0, 1'b0);
    flag(fop_add, 1'b0, 8'h7f, 8'h01, 16'h0, 1'b0);
    flag(fop_sub, 1'b0, 8'h00, 8'h01, 16'h0, 1'b0);
    flag(fop_move, 1'b1, 8'h0, 8'h0, 16'h8000, 1'b0);
    flag(fop_move, 1'b1, 8'h0, 8'h0, 16'h0000, 1'b0);
    flag(fop_move, 1'b0, 8'h0, 8'h0, 16'h0100, 1'b0);
    for (i = 0; i < 40; i++) begin
      flag(flag_op_t'(1 + $urandom % 8), 1'($urandom), 8'($urandom),
           8'($urandom), 16'($urandom), 1'($urandom));
    end
    flag(fop_clear_mask, 1'b0, 8'h0, 8'h0, 16'h0, 1'b0);
    flag(fop_set_mask, 1'b0, 8'h0, 8'h0, 16'h0, 1'b0);
    @(posedge clk);
    irq <= 1'b1;
    bnd_chk(1'b0);
    flag(fop_clear_mask, 1'b0, 8'h0, 8'h0, 16'h0, 1'b0);
    bnd_chk(1'b0);
    bnd_chk(1'b1);
    wait_saved();
    bnd_chk(1'b0);
    flag(fop_to_flags, 1'b0, 8'h00, 8'h0, 16'h0, 1'b0);
    bnd_chk(1'b0);
    bnd_chk(1'b1);
    wait_saved();
    @(posedge clk);
    irq <= 1'b0;
    addr_chk(branch_offset_mode, 1'b1, 1'b1, 1'b0, 3'd2, 8'h80);
    addr_chk(branch_offset_mode, 1'b1, 1'b1, 1'b0, 3'd2, 8'h7f);
    addr_chk(branch_offset_mode, 1'b1, 1'b0, 1'b0, 3'd2, 8'h80);
    for (i = 0; i < 48; i++) begin
      addr_chk(addr_mode_t'(i % 16), 1'($urandom), 1'($urandom),
               1'($urandom), 3'(1 + $urandom % 4), 8'($urandom));
    end
    addr_chk(mode_ext, 1'b0, 1'b0, 1'b0, 3'd3, 8'h00);
    axi_rd(OFS_EA, 32'(ea_m), RESP_OKAY);
    axi_rd(OFS_STAT, 32'({1'b1, 4'(mode_ext)}), RESP_OKAY);
    tally_and_finish();
  end
endmodule
